// *** bench/ieee488_status_service_request_tb.sv ***
/*
  testbench for the status byte block with a controller model.
  assumes a 50 MHz clock and pulses of one cycle on all commands.
*/
module ieee488_status_service_request_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg         clock, sys_rst, hw_err_active, ready_in, remote_in, got;
  reg  [7:0]  hw_err_code, mask_data, b;
  reg  [7:0]  c [0:2];                   // queued codes
  reg  [16:0] pu;                        // one bit per event or command
  reg  [31:0] rnd;                       // random state
  reg  [3:0]  e;                         // random event index
  reg  [2:0]  s;                         // expected {param, exec, sweep}
  wire [7:0]  status_byte, hw_err_out;
  wire        srq, hw_err_valid, pp_response, restore_display;
  wire        rem_ann, lst_ann, tlk_ann, srq_ann, lis, talker_annunciator, una, ifc, spl;
  integer     err_total, n_tests, i;
  integer     cyc = 0;                   // cycles since start, for the hang guard
  integer     n_restore;                 // display restore pulses seen since reset
  ssr_status dut_u (.CLOCK(clock), .SYS_RST(sys_rst), .SWEEP_DONE(pu[0]),
    .SWEEP_RESTART(pu[1]), .EXEC_ERR(pu[2]), .READ_EXEC_ERROR_CMD(pu[3]),
    .PARAM_CHANGED(pu[4]), .READ_PARAMETER_CHANGED_CMD(pu[5]), .CLEAR_STATUS_CMD(pu[6]),
    .DEVICE_CLEAR(pu[7]), .INSTRUMENT_PRESET_CMD(pu[8]), .LOOP_UNLOCK(pu[9]),
    .RPP_TRIP(pu[10]), .FW_FAULT(pu[11]), .READ_HARDWARE_ERROR_CMD(pu[12]),
    .MASK_WRITE(pu[13]), .GROUP_TRIGGER(pu[14]), .DOUBLE_SHIFT_DISPLAY_CMD(pu[15]),
    .SHIFT_KEY(pu[16]), .HW_ERR_CODE(hw_err_code), .HW_ERR_ACTIVE(hw_err_active),
    .READY_IN(ready_in), .MASK_DATA(mask_data), .REMOTE_IN(remote_in),
    .LISTEN_ADDR(lis), .TALK_ADDR(talker_annunciator), .UNADDRESS(una), .IFC(ifc), .SERIAL_POLL(spl),
    .STATUS_BYTE(status_byte), .SRQ(srq), .HW_ERR_VALID(hw_err_valid),
    .HW_ERR_OUT(hw_err_out), .PP_RESPONSE(pp_response), .RESTORE_DISPLAY(restore_display),
    .REMOTE_ANNUNCIATOR(rem_ann), .LISTENER_ANNUNCIATOR(lst_ann),
    .TALKER_ANNUNCIATOR(tlk_ann), .SERVICE_REQUEST_ANNUNCIATOR(srq_ann));
  ssr_ctl_model m (.clk(clock), .status_byte(status_byte), .hw_valid(hw_err_valid),
    .hw_code(hw_err_out), .listen(lis), .talk(talker_annunciator), .unaddr(una), .ifc(ifc), .poll(spl));
  // expected byte with ready high and no hardware error
  function [7:0] exp_byte(input [2:0] st);
    exp_byte = {st[2], 1'b0, st[1], 1'b1, ~remote_in, st[1], 1'b0, st[0]};
  endfunction
  // sticky bits after one event
  function [2:0] nxt(input [2:0] st, input [3:0] ev);
    case (ev)
      4'd0: nxt = st | 3'h1;
      4'd1: nxt = st & 3'h6;
      4'd2: nxt = st | 3'h2;
      4'd3: nxt = st & 3'h5;
      4'd4: nxt = st | 3'h4;
      4'd5: nxt = st & 3'h3;
      default: nxt = 3'h0;
    endcase
  endfunction
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [9:0] g, input [9:0] x);
    n_tests = n_tests + 1;
    if (g !== x) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one pulse, then time for the byte to settle
  task pulse(input [16:0] v);
    @(posedge clock) pu <= v;
    @(posedge clock) pu <= 17'h0;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // hang guard and restore pulse catcher
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (sys_rst) n_restore <= 0;
    else if (restore_display === 1'b1) n_restore <= n_restore + 1;
    if (cyc > 3000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  initial begin
    {err_total, n_tests, pu, s} = 0;
    {sys_rst, ready_in, remote_in, hw_err_active, hw_err_code, mask_data} = 20'he0000;
    rnd = 32'hc40f;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    pulse(17'h0);
    chk({rem_ann, status_byte}, 10'h110);
    @(posedge clock) remote_in <= 1'b0;
    settle;
    chk(status_byte, 8'h18);
    for (i = 0; i < 24; i = i + 1) begin
      rnd = lfsr(rnd);
      e = rnd[3:0] % 4'd9;
      pulse(17'h1 << e);
      s = nxt(s, e);
      chk(status_byte, exp_byte(s));
    end
    pulse(17'h100);
    @(posedge clock) hw_err_active <= 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      rnd = lfsr(rnd);
      c[i] = rnd[7:0];
      @(posedge clock) hw_err_code <= c[i];
      pulse(17'h200 << i);
    end
    chk(status_byte, 8'h3a);
    pulse(17'h40);
    chk(status_byte, 8'h3a);
    pulse(17'h1000);
    chk(status_byte, 8'h18);
    for (i = 0; i < 4; i = i + 1) begin
      m.talk_rd(got, b);
      chk({got, b}, (i < 3) ? {1'b1, c[i]} : 9'h0);
    end
    @(posedge clock) {hw_err_active, mask_data} <= 9'h080;
    pulse(17'h2000);
    pulse(17'h10);
    chk({srq_ann, srq, status_byte}, 10'h3d8);
    pulse(17'h20);
    chk({srq, status_byte}, 9'h1d8);
    m.spoll(b);
    chk(b, 8'hd8);
    pulse(17'h0);
    chk(status_byte, 8'h18);
    pulse(17'hc);
    chk(status_byte, 8'h3c);
    @(posedge clock) mask_data <= 8'hff;
    pulse(17'h2100);
    pulse(17'h4);
    chk({srq, status_byte}, 9'h03c);
    pulse(17'h4008);
    chk({pp_response, status_byte}, 9'h018);
    m.addr(4'h8);
    settle;
    chk({tlk_ann, lst_ann}, 2'b01);
    m.addr(4'h4);
    settle;
    chk({tlk_ann, lst_ann}, 2'b10);
    m.addr(4'h1);
    settle;
    chk({tlk_ann, lst_ann}, 2'b00);
    m.addr(4'h8);
    m.addr(4'h2);
    settle;
    chk(lst_ann, 1'b0);
    @(posedge clock) remote_in <= 1'b1;
    pulse(17'h8000);
    chk(n_restore[9:0], 10'd1);
    @(posedge clock) remote_in <= 1'b0;
    pulse(17'h10000);
    pulse(17'h10000);
    chk(n_restore[9:0], 10'd2);
    wrap_up;
  end
endmodule

// *** bench/ssr_ctl_model.sv ***
/*
  system controller model: serial poll, addressing and interface clear.
  assumes requests are taken on rising edges of clk.
*/
module ssr_ctl_model (
  // clock and device answers
  input  wire       clk,
  input  wire [7:0] status_byte,
  input  wire       hw_valid,
  input  wire [7:0] hw_code,
  // bus requests
  output reg        listen,
  output reg        talk,
  output reg        unaddr,
  output reg        ifc,
  output reg        poll
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {listen, talk, unaddr, ifc, poll} = 5'h0;
  // status is read only while a serial poll is held
  task spoll(output [7:0] b);
    @(posedge clk) poll <= 1'b1;
    @(negedge clk) b = status_byte;
    @(posedge clk) poll <= 1'b0;
  endtask
  // one pulse of {listen, talk, unaddress, clear}
  task addr(input [3:0] v);
    @(posedge clk) {listen, talk, unaddr, ifc} <= v;
    @(posedge clk) {listen, talk, unaddr, ifc} <= 4'h0;
  endtask
  // talk addressing repeated by the caller drains the queue
  task talk_rd(output got, output [7:0] c);
    integer i;
    got = 1'b0;
    c = 8'h00;
    addr(4'h4);
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge clk);
      #1;
      if (hw_valid === 1'b1) begin
        got = 1'b1;
        c = hw_code;
      end
    end
  endtask
endmodule

// *** bench/ssr_status_assertions.sv ***
/*
  checker for the status byte block: timing and relations at its ports.
  assumes one clock and the synchronous reset of the design.
*/
module ssr_status_chk (
  // clock and reset
  input wire       CLOCK,
  input wire       SYS_RST,
  // inputs watched
  input wire       EXEC_ERR,
  input wire       SWEEP_DONE,
  input wire       CLEAR_STATUS_CMD,
  input wire       TALK_ADDR,
  input wire       LISTEN_ADDR,
  input wire       UNADDRESS,
  input wire       IFC,
  input wire       SHIFT_KEY,
  input wire       DOUBLE_SHIFT_DISPLAY_CMD,
  // outputs watched
  input wire [7:0] STATUS_BYTE,
  input wire       SRQ,
  input wire       HW_ERR_VALID,
  input wire       PP_RESPONSE,
  input wire       RESTORE_DISPLAY,
  input wire       TALKER_ANNUNCIATOR,
  input wire       LISTENER_ANNUNCIATOR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // parallel poll line never driven
  pp_never_a: assert property (PP_RESPONSE == 1'b0)
    else $error("parallel poll response driven");
  // summary bit follows both error bits
  err_sum_a: assert property (STATUS_BYTE[5] == (STATUS_BYTE[1] | STATUS_BYTE[2]))
    else $error("error summary bit wrong");
  // an error shows two cycles on unless a held byte is on show
  exec_set_a: assert property (EXEC_ERR && !SRQ && !STATUS_BYTE[6] |-> ##2 STATUS_BYTE[2])
    else $error("execution error bit not set");
  // clear status drops the sweep bit when nothing sets it again
  sweep_clear_a: assert property (CLEAR_STATUS_CMD && !SWEEP_DONE && !STATUS_BYTE[6]
    ##1 !SWEEP_DONE |=> !STATUS_BYTE[0])
    else $error("sweep bit not cleared");
  // queue entries only answer a talk address
  hw_valid_a: assert property (HW_ERR_VALID |-> $past(TALK_ADDR, 2))
    else $error("queue entry without talk address");
  // display restore needs a shift cause
  restore_cause_a: assert property (RESTORE_DISPLAY |-> $past(DOUBLE_SHIFT_DISPLAY_CMD) ||
    $past(SHIFT_KEY))
    else $error("display restore without cause");
  // talk annunciator lights after a talk address
  talk_ann_a: assert property (TALK_ADDR && !IFC && !UNADDRESS ##1 !IFC && !UNADDRESS
    && !LISTEN_ADDR |=> TALKER_ANNUNCIATOR)
    else $error("talk annunciator dark");
  // interface clear ends talking and listening
  ifc_drop_a: assert property (IFC ##1 !TALK_ADDR && !LISTEN_ADDR |=>
    !TALKER_ANNUNCIATOR && !LISTENER_ANNUNCIATOR)
    else $error("addressing kept after interface clear");
endmodule

bind ssr_status ssr_status_chk chk_u (.*);

// *** design/ssr_err_mem.v ***
/*
  small memory for the hardware error queue; read data comes out of a
  register one clock after the read address is presented.
  assumes the caller never writes and reads an overflowed slot.
*/
module ssr_err_mem #(
  parameter DW = 8,                  // entry width
  parameter AW = 3                   // address width
) (
  input  wire          clk,          // instrument clock
  input  wire          we,           // write strobe
  input  wire [AW-1:0] waddr,        // write address
  input  wire [DW-1:0] wdata,        // write data
  input  wire [AW-1:0] raddr,        // read address
  output reg  [DW-1:0] rdata         // registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];    // storage array

  // write port and registered read port
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// *** design/ssr_regs.vh ***
/*
  constants for the status byte and service request block: bit positions,
  reset values and the width of the hardware error queue.
  assumes a single instrument clock and one inclusion per compile unit.
*/
`ifndef SSR_REGS_VH
`define SSR_REGS_VH

`define SSR_BIT_SWEEP     0
`define SSR_BIT_HW_ERR    1
`define SSR_BIT_EXEC_ERR  2
`define SSR_BIT_LOCAL     3
`define SSR_BIT_READY     4
`define SSR_BIT_ERR_SUM   5
`define SSR_BIT_RQS       6
`define SSR_BIT_PARAM_CHG 7

`define SSR_MASK_RESET    8'h00
`define SSR_STATUS_RESET  8'h00
`define SSR_RQS_EXCLUDE   8'hbf
`define SSR_HW_CODE_W     8
`define SSR_HW_DEPTH_LOG2 3

`endif

// *** design/ssr_status.v ***
/*
  status byte and service request logic of the remote interface: eight
  status bits, request mask, serial poll answer with held snapshot, error
  queue readout on talk, interface clear and the remote annunciators.
  assumes the bus protocol engine outside decodes commands into one-cycle
  strobes and that all inputs are synchronous to CLOCK.
*/
`include "ssr_regs.vh"

module ssr_status #(
  parameter QAW = `SSR_HW_DEPTH_LOG2   // log2 of error queue depth
) (
  // clock and reset
  input  wire       CLOCK,
  input  wire       SYS_RST,
  // instrument events, one-cycle pulses, except the levels HW_ERR_ACTIVE and READY_IN
  input  wire       SWEEP_DONE,        // single sweep finished
  input  wire       SWEEP_RESTART,     // auto, manual, new single or sweep off
  input  wire       LOOP_UNLOCK,       // synthesizer out of lock
  input  wire       RPP_TRIP,          // reverse power tripped
  input  wire       FW_FAULT,          // firmware malfunction
  input  wire [7:0] HW_ERR_CODE,       // code pushed with a hardware error
  input  wire       HW_ERR_ACTIVE,     // some hardware error still unresolved
  input  wire       EXEC_ERR,          // syntax or execution error
  input  wire       PARAM_CHANGED,     // setting altered automatically
  input  wire       READY_IN,          // processor part of setting done
  // decoded commands, one-cycle pulses
  input  wire       READ_HARDWARE_ERROR_CMD,
  input  wire       READ_EXEC_ERROR_CMD,
  input  wire       READ_PARAMETER_CHANGED_CMD,
  input  wire       CLEAR_STATUS_CMD,
  input  wire       INSTRUMENT_PRESET_CMD,
  input  wire       DEVICE_CLEAR,      // device or selected device clear
  input  wire       MASK_WRITE,        // request mask write strobe
  input  wire [7:0] MASK_DATA,         // new request mask
  input  wire       GROUP_TRIGGER,     // group execute trigger, ignored
  input  wire       DOUBLE_SHIFT_DISPLAY_CMD,
  input  wire       SHIFT_KEY,         // front-panel shift key pulse
  // bus addressing state
  input  wire       REMOTE_IN,         // remote state from bus engine
  input  wire       LISTEN_ADDR,       // addressed to listen pulse
  input  wire       TALK_ADDR,         // addressed to talk pulse
  input  wire       UNADDRESS,         // untalk, unlisten or other talker
  input  wire       IFC,               // interface clear
  input  wire       SERIAL_POLL,       // serial poll read of status byte
  // outputs
  output reg  [7:0] STATUS_BYTE,       // byte answered on serial poll
  output reg        SRQ,               // service request line assert
  output reg        HW_ERR_VALID,      // queue entry presented on talk
  output reg  [7:0] HW_ERR_OUT,        // queue entry
  output reg        PP_RESPONSE,       // parallel poll drive, always low
  output reg        RESTORE_DISPLAY,   // show last settings pulse
  output reg        REMOTE_ANNUNCIATOR,
  output reg        LISTENER_ANNUNCIATOR,
  output reg        TALKER_ANNUNCIATOR,
  output reg        SERVICE_REQUEST_ANNUNCIATOR
);
  localparam QD = 1 << QAW;            // queue depth

  // status bit registers and next values
  reg        sweep_q, sweep_d;         // bit 0
  reg        hw_q, hw_d;               // bit 1
  reg        exec_q, exec_d;           // bit 2
  reg        chg_q, chg_d;             // bit 7
  reg  [7:0] mask_q;                   // request mask
  reg  [7:0] held_q;                   // snapshot held while request stands
  reg        held_v_q;                 // snapshot valid
  reg        listen_q;                 // listener state
  reg        talk_q;                   // talker state
  reg        oh_arm_q;                 // error readout armed
  reg        shift_q;                  // first shift seen in local
  reg        rd_pend_q;                // memory read in flight
  reg  [QAW-1:0] wr_ptr_q;             // queue write pointer
  reg  [QAW-1:0] rd_ptr_q;             // queue read pointer
  reg  [QAW:0]   cnt_q;                // queue occupancy
  wire [7:0] mem_rdata;                // registered queue data

  // combined status and request
  wire       clr_all  = CLEAR_STATUS_CMD | INSTRUMENT_PRESET_CMD | DEVICE_CLEAR;
  wire       hw_event = LOOP_UNLOCK | RPP_TRIP | FW_FAULT;
  wire [7:0] live;                     // live status without bit 6
  wire       rqs_live;                 // masked request term
  wire       push     = hw_event & (cnt_q != QD[QAW:0]);
  wire       pop      = TALK_ADDR & oh_arm_q & (cnt_q != {(QAW+1){1'b0}});

  assign live = {chg_q, 1'b0, hw_q | exec_q, READY_IN, ~REMOTE_IN,
                 exec_q, hw_q, sweep_q};
  assign rqs_live = |(live & mask_q & `SSR_RQS_EXCLUDE);

  // next values of the sticky bits; set is applied last so it wins
  always @* begin
    sweep_d = sweep_q;
    hw_d    = hw_q;
    exec_d  = exec_q;
    chg_d   = chg_q;
    if (SWEEP_RESTART | clr_all) begin
      sweep_d = 1'b0;
    end
    if (READ_HARDWARE_ERROR_CMD) begin
      hw_d = 1'b0;
    end else if (clr_all & ~HW_ERR_ACTIVE) begin
      hw_d = 1'b0;
    end
    if (READ_EXEC_ERROR_CMD | clr_all) begin
      exec_d = 1'b0;
    end
    if (READ_PARAMETER_CHANGED_CMD | clr_all) begin
      chg_d = 1'b0;
    end
    if (SWEEP_DONE) begin
      sweep_d = 1'b1;
    end
    if (hw_event) begin
      hw_d = 1'b1;
    end
    if (EXEC_ERR) begin
      exec_d = 1'b1;
    end
    if (PARAM_CHANGED) begin
      chg_d = 1'b1;
    end
  end

  // sticky bits and mask
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      sweep_q <= 1'b0;
      hw_q    <= 1'b0;
      exec_q  <= 1'b0;
      chg_q   <= 1'b0;
      mask_q  <= `SSR_MASK_RESET;
    end else begin
      sweep_q <= sweep_d;
      hw_q    <= hw_d;
      exec_q  <= exec_d;
      chg_q   <= chg_d;
      if (INSTRUMENT_PRESET_CMD) begin
        mask_q <= `SSR_MASK_RESET;
      end else if (MASK_WRITE) begin
        mask_q <= MASK_DATA;
      end
    end
  end

  // snapshot: freezes the byte when request first rises, refreshed by a
  // poll; a bit cleared while held still shows on the next poll
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      held_q   <= `SSR_STATUS_RESET;
      held_v_q <= 1'b0;
    end else if (SERIAL_POLL) begin
      // reading never clears a sticky bit; it refreshes the snapshot and drops bit 6 when no masked request is live
      held_q   <= live | 8'h40;
      held_v_q <= rqs_live;
    end else if (~held_v_q & rqs_live) begin
      held_q   <= live | 8'h40;
      held_v_q <= 1'b1;
    end
  end

  // status byte, request line and annunciators
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      STATUS_BYTE                 <= `SSR_STATUS_RESET;
      SRQ                         <= 1'b0;
      SERVICE_REQUEST_ANNUNCIATOR <= 1'b0;
      REMOTE_ANNUNCIATOR          <= 1'b0;
      PP_RESPONSE                 <= 1'b0;
    end else begin
      if (held_v_q) begin
        STATUS_BYTE <= held_q;
      end else begin
        STATUS_BYTE <= live | {1'b0, rqs_live, 6'h00};
      end
      SRQ                         <= held_v_q | rqs_live;
      SERVICE_REQUEST_ANNUNCIATOR <= held_v_q | rqs_live;
      REMOTE_ANNUNCIATOR          <= REMOTE_IN;
      PP_RESPONSE                 <= 1'b0;
    end
  end

  // talker and listener state; interface clear drops both at once
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      listen_q             <= 1'b0;
      talk_q               <= 1'b0;
      LISTENER_ANNUNCIATOR <= 1'b0;
      TALKER_ANNUNCIATOR   <= 1'b0;
    end else begin
      if (IFC | UNADDRESS) begin
        listen_q <= 1'b0;
        talk_q   <= 1'b0;
      end else if (LISTEN_ADDR) begin
        listen_q <= 1'b1;
        talk_q   <= 1'b0;
      end else if (TALK_ADDR) begin
        talk_q   <= 1'b1;
        listen_q <= 1'b0;
      end
      LISTENER_ANNUNCIATOR <= listen_q & ~IFC;
      TALKER_ANNUNCIATOR   <= talk_q & ~IFC;
    end
  end

  // hardware error queue pointers and readout, one entry per talk
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      wr_ptr_q     <= {QAW{1'b0}};
      rd_ptr_q     <= {QAW{1'b0}};
      cnt_q        <= {(QAW+1){1'b0}};
      oh_arm_q     <= 1'b0;
      rd_pend_q    <= 1'b0;
      HW_ERR_VALID <= 1'b0;
      HW_ERR_OUT   <= 8'h00;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
      if (READ_HARDWARE_ERROR_CMD) begin
        oh_arm_q <= 1'b1;
      end else if (IFC | clr_all) begin
        oh_arm_q <= 1'b0;
      end
      rd_pend_q    <= pop;
      HW_ERR_VALID <= rd_pend_q;
      if (rd_pend_q) begin
        HW_ERR_OUT <= mem_rdata;
      end
    end
  end

  // display restore on second shift in local or remote code; the group
  // trigger is deliberately not looked at anywhere
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      shift_q         <= 1'b0;
      RESTORE_DISPLAY <= 1'b0;
    end else begin
      RESTORE_DISPLAY <= (REMOTE_IN & DOUBLE_SHIFT_DISPLAY_CMD) |
                         (~REMOTE_IN & SHIFT_KEY & shift_q);
      if (REMOTE_IN) begin
        shift_q <= 1'b0;
      end else if (SHIFT_KEY) begin
        shift_q <= ~shift_q;
      end
    end
  end

  // queue storage
  ssr_err_mem #(
    .DW (`SSR_HW_CODE_W),
    .AW (QAW)
  ) u_mem (
    .clk   (CLOCK),
    .we    (push),
    .waddr (wr_ptr_q),
    .wdata (HW_ERR_CODE),
    .raddr (rd_ptr_q),
    .rdata (mem_rdata)
  );
endmodule
